/* hdl/ast_params.svh */
// Timing counts and field positions for the asynchronous serial transceiver
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH
`define AST_CLK_PERIOD_NS   20
`define AST_TICKS_PER_BIT   16
`define AST_PHASE_LAST      4'hF
`define AST_SAMPLE_PHASE    4'h7
`define AST_OUT_CLK_BIT     3
`define AST_ERR_OVERRUN     0
`define AST_ERR_FRAMING     1
`define AST_ERR_PARITY      2
`define AST_DATA_W          8
`define AST_BUF_DEPTH       2
`define AST_BAUD_DIV_RESET  8'h00
`endif

/* hdl/ast_pkg.sv */
// Types shared by the asynchronous serial transceiver files
package ast_pkg;
  typedef logic [2:0] ast_err_t;
  typedef logic [7:0] ast_byte_t;
  typedef enum logic [2:0] {
    AST_TX_PREAMBLE = 3'h0,
    AST_TX_IDLE     = 3'h1,
    AST_TX_START    = 3'h3,
    AST_TX_DATA     = 3'h2,
    AST_TX_PARITY   = 3'h6,
    AST_TX_STOP1    = 3'h7,
    AST_TX_STOP2    = 3'h5
  } ast_tx_state_e;
  typedef enum logic [2:0] {
    AST_RX_IDLE   = 3'h0,
    AST_RX_START  = 3'h1,
    AST_RX_DATA   = 3'h3,
    AST_RX_PARITY = 3'h2,
    AST_RX_STOP   = 3'h6
  } ast_rx_state_e;
endpackage

/* hdl/ast_stream_if.sv */
// Valid/ready word carrier between the transceiver and its buffer
`timescale 1ns/10ps
interface ast_stream_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* hdl/ast_pair_buf.sv */
// Two-entry flop buffer with valid and ready on both sides
`timescale 1ns/10ps
module ast_pair_buf #(
  parameter int W     = 9,
  parameter int DEPTH = 2
) (
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  input  wire logic   i_ce,
  ast_stream_if.snk   s_in,
  ast_stream_if.src   s_out
);
  import ast_pkg::*;

  initial begin
    if (DEPTH != 2 || W < 1) begin
      $error("ast_pair_buf supports DEPTH 2 and W >= 1 only");
    end
  end

  logic [W-1:0] mem [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  wire          push = i_ce & s_in.valid & s_in.ready;
  wire          pop  = i_ce & s_out.valid & s_out.ready;

  assign s_in.ready  = (count != 2'h2);
  assign s_out.valid = (count != 2'h0);
  assign s_out.data  = mem[rd_ptr];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= s_in.data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule

/* hdl/ast_serial_top.sv */
// Asynchronous serial transceiver: clock select, framed transmit and receive, flags
`timescale 1ns/10ps
`include "ast_params.svh"

// Overview of operation
// [RQ1] Mode, external-source and pin-output selects decide clock source and clock pin role.
// [RQ2] An external clock must run at sixteen times the bit rate.
// [RQ3] Output clock runs at bit rate, rising edge at each bit centre.
// [RQ4] Line idles high; a low level begins a received character.
// [RQ5] Frame: low start, data LSB first, optional parity or tag, high stops.
// [RQ6] Twelve formats from length, parity, stop count and tag-format selects.
// [RQ7] Receiver syncs on start edge and samples each bit on eighth tick.
// [RQ8] Transmit and receive run independently, each double-buffered.
// [RQ9] Dropping transmit enable sets the empty flag and resets the shifter.
// [RQ10] Dropping receive enable keeps receive flags and received byte.
// [RQ11] After transmit enable, one idle frame of ones precedes the first character.
// [RQ12] Cleared empty flag means new data: copy to shifter, set flag, send.
// [RQ13] Transmit-empty request raised at the copy when its enable is set.
// [RQ14] During stop bit: chain next byte, or set done flag and request.
// [RQ15] Parity checked against odd or even selection when parity is on.
// [RQ16] First stop bit must be one; a second one is not checked.
// [RQ17] Good character with empty receive buffer is stored and sets full flag.
// [RQ18] Any receive error leaves full flag clear and halts reception until cleared.
// [RQ19] Full flag with receive interrupt enable requests receive-full.
// [RQ20] Any error flag with receive interrupt enable requests receive-error.
// [RQ21] Character completing while full flag still set raises overrun.
// [RQ22] Framing or parity error still stores the data into the buffer.
module ast_serial_top #(
  parameter int BAUD_DIV_W = 8
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_ce,
  input  wire logic            i_sync_mode_sel,
  input  wire logic            i_clk_src_ext,
  input  wire logic            i_clk_pin_out,
  input  wire logic [BAUD_DIV_W-1:0] i_baud_div,
  input  wire logic            i_char_len7,
  input  wire logic            i_parity_on,
  input  wire logic            i_odd_parity_sel,
  input  wire logic            i_multiproc_format,
  input  wire logic            i_stop_count,
  input  wire logic            i_transmit_enable,
  input  wire logic            i_rx_enable_bit,
  input  wire logic            i_tx_empty_irq_en,
  input  wire logic            i_tx_done_irq_en,
  input  wire logic            i_rx_irq_en,
  input  wire logic            i_tx_valid,
  input  wire ast_pkg::ast_byte_t i_tx_data,
  input  wire logic            i_address_tag_bit,
  output logic                 o_tx_ready,
  input  wire logic            i_rx_full_clr,
  input  wire ast_pkg::ast_err_t i_err_clr,
  input  wire logic            i_sck,
  output logic                 o_sck,
  output logic                 o_sck_oe_n,
  input  wire logic            i_rx_line,
  output logic                 o_tx_line,
  output logic                 o_tx_empty_flag,
  output logic                 o_tx_done_flag,
  output logic                 o_rx_full_flag,
  output ast_pkg::ast_err_t    o_err_flags,
  output ast_pkg::ast_byte_t   o_rx_data_buffer,
  output logic                 o_rx_tag,
  output logic                 o_tx_empty_irq,
  output logic                 o_tx_done_irq,
  output logic                 o_rx_full_irq,
  output logic                 o_rx_error_irq
);
  import ast_pkg::*;

  initial begin
    if (BAUD_DIV_W < 1 || BAUD_DIV_W > 16) begin
      $error("ast_serial_top: BAUD_DIV_W must be 1..16");
    end
  end

  // Clock source and pin role
  logic                  sck_prev;
  logic [BAUD_DIV_W-1:0] div_cnt;
  logic [3:0]            tx_phase;
  wire ext_src   = i_clk_src_ext;                                      // [RQ1]
  wire pin_drive = ~i_clk_src_ext & (i_sync_mode_sel | i_clk_pin_out); // [RQ1]
  wire ext_tick  = i_sck & ~sck_prev;                                  // [RQ2]
  wire int_tick  = (div_cnt == i_baud_div);
  wire tick      = ext_src ? ext_tick : int_tick;
  wire bit_end   = tick & (tx_phase == `AST_PHASE_LAST);

  assign o_sck_oe_n = ~pin_drive;
  // High for the second half of each bit, so the rising edge lands mid-bit
  assign o_sck      = pin_drive & tx_phase[`AST_OUT_CLK_BIT];           // [RQ3]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_prev <= 1'b0;
      div_cnt  <= BAUD_DIV_W'(`AST_BAUD_DIV_RESET);
      tx_phase <= 4'h0;
    end else if (i_ce) begin
      sck_prev <= i_sck;
      div_cnt  <= int_tick ? '0 : div_cnt + {{(BAUD_DIV_W-1){1'b0}}, 1'b1};
      if (tick) begin
        tx_phase <= tx_phase + 4'h1;
      end
    end
  end

  // Frame shape
  wire       has_extra  = i_multiproc_format | i_parity_on;            // [RQ6]
  wire [3:0] data_last  = i_char_len7 ? 4'h6 : 4'h7;                    // [RQ6]
  wire [3:0] frame_last = data_last + 4'h2 + {3'h0, has_extra} + {3'h0, i_stop_count};

  // Software-side buffer: pops only while the empty flag is set
  ast_stream_if #(.W(`AST_DATA_W + 1)) wr_if ();
  ast_stream_if #(.W(`AST_DATA_W + 1)) rd_if ();
  logic tx_empty;

  assign wr_if.valid = i_tx_valid;
  assign wr_if.data  = {i_address_tag_bit, i_tx_data};
  assign o_tx_ready  = wr_if.ready;
  assign rd_if.ready = tx_empty & i_transmit_enable;

  ast_pair_buf #(
    .W     (`AST_DATA_W + 1),
    .DEPTH (`AST_BUF_DEPTH)
  ) u_buf (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .s_in    (wr_if),
    .s_out   (rd_if)
  );

  // Transmitter
  ast_tx_state_e tx_state;
  ast_byte_t     tx_data_buffer;
  ast_byte_t     tx_shift_reg;
  logic          tx_tag_buf;
  logic          tx_extra_bit;
  logic          tx_done;
  logic          tx_chain;
  logic          tx_line;
  logic [3:0]    tx_cnt;
  // Writing the buffer and clearing the flag happen together at the pop
  wire tx_write     = i_ce & rd_if.valid & rd_if.ready;
  wire tx_last_stop = (tx_state == AST_TX_STOP1 && !i_stop_count) ||
                      (tx_state == AST_TX_STOP2);
  wire tx_have_new  = ~tx_empty;
  wire [7:0] tx_masked = i_char_len7 ? {1'b0, tx_data_buffer[6:0]} : tx_data_buffer;
  // Parity covers only the bits sent, so an unused top bit cannot flip it
  wire parity_calc  = ^tx_masked ^ i_odd_parity_sel;                     // [RQ5]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state       <= AST_TX_PREAMBLE;
      tx_data_buffer <= 8'h00;
      tx_shift_reg   <= 8'h00;
      tx_tag_buf     <= 1'b0;
      tx_extra_bit   <= 1'b0;
      tx_empty       <= 1'b1;
      tx_done        <= 1'b1;
      tx_chain       <= 1'b0;
      tx_line        <= 1'b1;
      tx_cnt         <= 4'h0;
    end else if (i_ce) begin
      if (!i_transmit_enable) begin
        tx_state     <= AST_TX_PREAMBLE;                               // [RQ9]
        tx_empty     <= 1'b1;                                          // [RQ9]
        tx_shift_reg <= 8'h00;                                         // [RQ9]
        tx_line      <= 1'b1;
        tx_cnt       <= 4'h0;
        tx_chain     <= 1'b0;
      end else begin
        if (tx_write) begin
          tx_data_buffer <= rd_if.data[7:0];
          tx_tag_buf     <= rd_if.data[8];
          tx_empty       <= 1'b0;
          tx_done        <= 1'b0;
        end
        if (bit_end) begin
          case (tx_state)
            AST_TX_PREAMBLE: begin
              tx_line <= 1'b1;                                         // [RQ11]
              tx_cnt  <= tx_cnt + 4'h1;
              if (tx_cnt == frame_last) begin                          // [RQ11]
                tx_state <= AST_TX_IDLE;
                tx_cnt   <= 4'h0;
              end
            end
            AST_TX_IDLE: begin
              tx_line <= 1'b1;                                         // [RQ4]
              if (tx_have_new) begin                                   // [RQ12]
                tx_shift_reg <= tx_masked;
                tx_extra_bit <= i_multiproc_format ? tx_tag_buf : parity_calc;
                tx_empty     <= 1'b1;                                  // [RQ12]
                tx_state     <= AST_TX_START;
                tx_line      <= 1'b0;                                  // [RQ5]
              end
            end
            AST_TX_START: begin
              tx_line      <= tx_shift_reg[0];                         // [RQ5]
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              tx_cnt       <= 4'h0;
              tx_state     <= AST_TX_DATA;
            end
            AST_TX_DATA: begin
              if (tx_cnt == data_last) begin
                tx_cnt <= 4'h0;
                if (has_extra) begin                                   // [RQ6]
                  tx_line  <= tx_extra_bit;                            // [RQ5]
                  tx_state <= AST_TX_PARITY;
                end else begin
                  tx_line  <= 1'b1;
                  tx_state <= AST_TX_STOP1;
                end
              end else begin
                tx_cnt       <= tx_cnt + 4'h1;
                tx_line      <= tx_shift_reg[0];
                tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              end
            end
            AST_TX_PARITY: begin
              tx_line  <= 1'b1;
              tx_state <= AST_TX_STOP1;
            end
            AST_TX_STOP1: begin
              tx_line  <= 1'b1;
              tx_state <= i_stop_count ? AST_TX_STOP2 : AST_TX_IDLE;   // [RQ6]
            end
            AST_TX_STOP2: begin
              tx_line  <= 1'b1;
              tx_state <= AST_TX_IDLE;
            end
            default: begin
              tx_line  <= 1'b1;
              tx_state <= AST_TX_PREAMBLE;
            end
          endcase
          // The empty flag is tested as the final stop bit begins
          if ((tx_state == AST_TX_PARITY || (tx_state == AST_TX_DATA &&
               tx_cnt == data_last && !has_extra)) && !i_stop_count ||
              (tx_state == AST_TX_STOP1 && i_stop_count)) begin
            if (tx_have_new) begin                                     // [RQ14]
              tx_chain <= 1'b1;
            end else begin
              tx_done  <= 1'b1;                                        // [RQ14]
              tx_chain <= 1'b0;
            end
          end
          if (tx_last_stop && tx_chain) begin                          // [RQ14]
            tx_shift_reg <= tx_masked;
            tx_extra_bit <= i_multiproc_format ? tx_tag_buf : parity_calc;
            tx_empty     <= 1'b1;                                      // [RQ12]
            tx_state     <= AST_TX_START;
            tx_line      <= 1'b0;
            tx_chain     <= 1'b0;
          end
        end
      end
    end
  end

  assign o_tx_line       = tx_line;
  assign o_tx_empty_flag = tx_empty;
  assign o_tx_done_flag  = tx_done;
  // Requests stay high while flag and enables are all set, so none is missed
  assign o_tx_empty_irq  = tx_empty & i_tx_empty_irq_en & i_transmit_enable; // [RQ13]
  assign o_tx_done_irq   = tx_done & i_tx_done_irq_en;                 // [RQ14]

  // Receiver, independent of the transmitter
  ast_rx_state_e rx_state;
  ast_byte_t     rx_shift_reg;
  ast_byte_t     rx_data_buffer;
  logic          rx_par_bit;
  logic          rx_tag;
  logic          rx_full;
  ast_err_t      err;
  logic [3:0]    rx_phase;
  logic [3:0]    rx_cnt;
  wire rx_run    = i_rx_enable_bit & (err == 3'h0);                    // [RQ18]
  wire rx_sample = tick & (rx_phase == `AST_SAMPLE_PHASE);             // [RQ7]
  wire [7:0] rx_word = i_char_len7 ? {1'b0, rx_shift_reg[7:1]} : rx_shift_reg;
  wire par_bad   = i_parity_on & ~i_multiproc_format &
                   ((^rx_word ^ rx_par_bit) != i_odd_parity_sel);      // [RQ15]
  wire stop_bad  = ~i_rx_line;                                         // [RQ16]
  wire rx_done   = rx_sample & rx_run & (rx_state == AST_RX_STOP);     // [RQ10]
  wire set_ovr   = rx_done & rx_full;                                  // [RQ21]
  wire set_fer   = rx_done & ~rx_full & stop_bad;                      // [RQ22]
  wire set_per   = rx_done & ~rx_full & par_bad;                       // [RQ22]
  wire store     = rx_done & ~rx_full;                                 // [RQ17]
  wire set_full  = store & ~stop_bad & ~par_bad;                       // [RQ17]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_state       <= AST_RX_IDLE;
      rx_shift_reg   <= 8'h00;
      rx_data_buffer <= 8'h00;
      rx_par_bit     <= 1'b0;
      rx_tag         <= 1'b0;
      rx_full        <= 1'b0;
      err            <= 3'h0;
      rx_phase       <= 4'h0;
      rx_cnt         <= 4'h0;
    end else if (i_ce) begin
      // Set wins over a clear in the same cycle
      rx_full <= set_full | (rx_full & ~i_rx_full_clr);                // [RQ19]
      err[`AST_ERR_OVERRUN] <= set_ovr | (err[`AST_ERR_OVERRUN] & ~i_err_clr[`AST_ERR_OVERRUN]);
      err[`AST_ERR_FRAMING] <= set_fer | (err[`AST_ERR_FRAMING] & ~i_err_clr[`AST_ERR_FRAMING]);
      err[`AST_ERR_PARITY]  <= set_per | (err[`AST_ERR_PARITY] & ~i_err_clr[`AST_ERR_PARITY]);
      if (store) begin
        rx_data_buffer <= rx_word;                                     // [RQ22]
        rx_tag         <= rx_par_bit;
      end
      // Disabling only idles the receiver; flags and buffer keep their values
      if (!rx_run) begin
        rx_state <= AST_RX_IDLE;                                       // [RQ10]
      end else if (tick) begin
        rx_phase <= rx_phase + 4'h1;
        case (rx_state)
          AST_RX_IDLE: begin
            if (!i_rx_line) begin                                      // [RQ4]
              rx_state <= AST_RX_START;
              rx_phase <= 4'h1;                                        // [RQ7]
            end
          end
          AST_RX_START: begin
            if (rx_sample) begin
              // A glitch that is high at mid-bit is not a start bit
              rx_state <= i_rx_line ? AST_RX_IDLE : AST_RX_DATA;
              rx_cnt   <= 4'h0;
            end
          end
          AST_RX_DATA: begin
            if (rx_sample) begin
              rx_shift_reg <= {i_rx_line, rx_shift_reg[7:1]};          // [RQ7]
              rx_cnt       <= rx_cnt + 4'h1;
              if (rx_cnt == data_last) begin
                rx_state <= has_extra ? AST_RX_PARITY : AST_RX_STOP;
              end
            end
          end
          AST_RX_PARITY: begin
            if (rx_sample) begin
              rx_par_bit <= i_rx_line;
              rx_state   <= AST_RX_STOP;
            end
          end
          AST_RX_STOP: begin
            // Only the first stop bit is checked; the second reads as idle
            if (rx_sample) begin
              rx_state <= AST_RX_IDLE;                                 // [RQ16]
            end
          end
          default: begin
            rx_state <= AST_RX_IDLE;
          end
        endcase
      end
    end
  end

  assign o_rx_full_flag   = rx_full;
  assign o_err_flags      = err;
  assign o_rx_data_buffer = rx_data_buffer;
  assign o_rx_tag         = rx_tag;
  assign o_rx_full_irq    = rx_full & i_rx_irq_en;                     // [RQ19]
  assign o_rx_error_irq   = (err != 3'h0) & i_rx_irq_en;               // [RQ20]
  // Both directions share only the tick source and the length, parity and tag-format selects   // [RQ8]
endmodule

/* dv/ast_serial_assertions.sv */
// Concurrent checks on the serial transceiver top ports
`timescale 1ns/10ps
module ast_serial_chk (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_ce,
  input wire logic       i_sync_mode_sel,
  input wire logic       i_clk_src_ext,
  input wire logic       i_clk_pin_out,
  input wire logic       i_transmit_enable,
  input wire logic       i_rx_enable_bit,
  input wire logic       i_tx_empty_irq_en,
  input wire logic       i_tx_done_irq_en,
  input wire logic       i_rx_irq_en,
  input wire logic       i_rx_full_clr,
  input wire logic [2:0] i_err_clr,
  input wire logic       o_sck,
  input wire logic       o_sck_oe_n,
  input wire logic       o_tx_line,
  input wire logic       o_tx_empty_flag,
  input wire logic       o_tx_done_flag,
  input wire logic       o_rx_full_flag,
  input wire logic [2:0] o_err_flags,
  input wire logic [7:0] o_rx_data_buffer,
  input wire logic       o_tx_empty_irq,
  input wire logic       o_tx_done_irq,
  input wire logic       o_rx_full_irq,
  input wire logic       o_rx_error_irq
);
  // Clocks since enable rose; 144 = shortest frame
  logic [7:0] te_age;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      te_age <= 8'h00;
    else if (!i_transmit_enable)
      te_age <= 8'h00;
    else if (i_ce && te_age != 8'hFF)
      te_age <= te_age + 8'h01;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_start_low; !o_tx_line [*8]; endsequence
  sequence s_idle_tx; o_tx_empty_flag && o_tx_line; endsequence
  property p_pin; o_sck_oe_n == !(!i_clk_src_ext && (i_sync_mode_sel || i_clk_pin_out)); endproperty
  property p_start; $rose(o_tx_empty_flag) && $past(i_transmit_enable) |-> s_start_low; endproperty
  property p_sck; o_sck_oe_n |-> !o_sck; endproperty
  property p_preamble; $fell(o_tx_line) |-> te_age >= 8'h90; endproperty
  property p_te_off; $fell(i_transmit_enable) && i_ce |-> ##[1:2] s_idle_tx; endproperty
  property p_done;
    $rose(o_tx_done_flag) |-> s_idle_tx ##0 (o_tx_done_irq == i_tx_done_irq_en);
  endproperty
  property p_txe_irq;
    o_tx_empty_irq == (o_tx_empty_flag && i_tx_empty_irq_en && i_transmit_enable);
  endproperty
  property p_rxf_irq; o_rx_full_irq == (o_rx_full_flag && i_rx_irq_en); endproperty
  property p_rxe_irq; o_rx_error_irq == (o_err_flags != 3'h0 && i_rx_irq_en); endproperty
  property p_rx_hold;
    !i_rx_enable_bit && !i_rx_full_clr && i_err_clr == 3'h0 |=>
      $stable(o_rx_full_flag) && $stable(o_err_flags) && $stable(o_rx_data_buffer);
  endproperty
  property p_err_block; o_err_flags != 3'h0 |=> !$rose(o_rx_full_flag); endproperty
  a_pin: assert property (p_pin) else $error("clock pin role wrong");
  a_sck: assert property (p_sck) else $error("clock pin driven while off");
  a_start: assert property (p_start) else $error("start bit malformed");
  a_preamble: assert property (p_preamble) else $error("start before idle frame");
  a_te_off: assert property (p_te_off) else $error("disable did not reset tx");
  a_done: assert property (p_done) else $error("done flag or request wrong");
  a_txe_irq: assert property (p_txe_irq) else $error("tx empty request wrong");
  a_rxf_irq: assert property (p_rxf_irq) else $error("rx full request wrong");
  a_rxe_irq: assert property (p_rxe_irq) else $error("rx error request wrong");
  a_rx_hold: assert property (p_rx_hold) else $error("rx state moved while off");
  a_err_block: assert property (p_err_block) else $error("rx stored after error");
endmodule

/* dv/ast_remote_peer.sv */
// Remote serial party: frame sender and catcher
`timescale 1ns/10ps
module ast_remote_peer #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic i_clk,
  input  wire logic i_line,
  input  int        i_frame_bits,
  output logic      o_line
);
  logic        prev = 1'b1;
  logic [11:0] cap;
  logic [11:0] rx_q[$];
  initial o_line = 1'b1;
  // Called at a rising edge
  task automatic send_frame(input logic [11:0] v, input int nb);
    o_line <= 1'b0;
    repeat (BIT_CLKS) @(posedge i_clk);
    for (int i = 0; i < nb - 1; i++) begin
      o_line <= v[i];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    o_line <= 1'b1;
  endtask
  // Falling-edge sampling sees settled data
  always @(negedge i_clk) begin
    if (prev && !i_line) begin
      repeat (BIT_CLKS / 2 - 1) @(negedge i_clk);
      cap = 12'hFFF;
      for (int i = 0; i < i_frame_bits - 1; i++) begin
        repeat (BIT_CLKS) @(negedge i_clk);
        cap[i] = i_line;
      end
      rx_q.push_back(cap);
    end
    prev = i_line;
  end
endmodule

/* dv/ast_serial_tb_top.sv */
// Self-checking bench for the serial transceiver
`timescale 1ns/10ps
`include "ast_params.svh"
module ast_serial_tb_top;
  import ast_pkg::*;
  logic      i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_sck = 1'b0;
  logic      i_sync_mode_sel = 1'b0, i_clk_src_ext = 1'b0, i_clk_pin_out = 1'b0;
  logic [7:0] i_baud_div = 8'h00;
  logic      i_char_len7 = 1'b0, i_parity_on = 1'b0, i_odd_parity_sel = 1'b0;
  logic      i_multiproc_format = 1'b0, i_stop_count = 1'b0, i_transmit_enable = 1'b0;
  logic      i_rx_enable_bit = 1'b0, i_tx_empty_irq_en = 1'b0, i_tx_done_irq_en = 1'b0;
  logic      i_rx_irq_en = 1'b1, i_tx_valid = 1'b0, i_address_tag_bit = 1'b0;
  logic      i_rx_full_clr = 1'b0, i_rx_line, o_tx_ready, o_sck, o_sck_oe_n, o_tx_line;
  ast_byte_t i_tx_data = 8'h00, o_rx_data_buffer;
  ast_err_t  i_err_clr = 3'h0, o_err_flags;
  logic      o_tx_empty_flag, o_tx_done_flag, o_rx_full_flag, o_rx_tag;
  logic      o_tx_empty_irq, o_tx_done_irq, o_rx_full_irq, o_rx_error_irq;
  int        errors = 0, checked = 0, fbits = 10, k;
  always #(`AST_CLK_PERIOD_NS / 2) i_clk = ~i_clk;
  always @(posedge i_clk) i_sck <= ~i_sck;
  ast_serial_top #(.BAUD_DIV_W(8)) dut (.*);
  ast_remote_peer peer (.i_clk, .i_line(o_tx_line), .i_frame_bits(fbits), .o_line(i_rx_line));
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic report_and_stop();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word(12'(got), 12'(exp));
  endtask
  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Line bits after start, LSB first
  function automatic logic [11:0] body(input ast_byte_t d, input logic tag);
    logic [11:0] v;
    logic        p;
    int          n;
    v = 12'hFFF;
    p = i_odd_parity_sel;
    n = i_char_len7 ? 7 : 8;
    for (int i = 0; i < n; i++) begin
      v[i] = d[i];
      p = p ^ d[i];
    end
    if (i_multiproc_format || i_parity_on)
      v[n] = i_multiproc_format ? tag : p;
    return v;
  endfunction
  task automatic set_fmt(input logic [3:0] f);
    i_char_len7 <= f[0];
    i_parity_on <= f[1];
    i_stop_count <= f[2];
    i_multiproc_format <= f[3];
    i_odd_parity_sel <= f[1] ^ f[0];
    i_clk_pin_out <= f[2];
    i_tx_empty_irq_en <= f[0];
    i_tx_done_irq_en <= f[1];
    fbits = 10 - f[0] + (f[1] | f[3]) + f[2];
  endtask
  task automatic write_byte(input ast_byte_t d, input logic tag);
    @(posedge i_clk);
    i_tx_valid <= 1'b1;
    i_tx_data <= d;
    i_address_tag_bit <= tag;
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while (o_tx_ready !== 1'b1 && k < 4000);
    @(posedge i_clk);
    i_tx_valid <= 1'b0;
  endtask
  task automatic rx(input logic [11:0] v);
    @(posedge i_clk);
    peer.send_frame(v, fbits);
    tick(2);
  endtask
  task automatic clr(input logic full, input ast_err_t e);
    @(posedge i_clk);
    i_rx_full_clr <= full;
    i_err_clr <= e;
    @(posedge i_clk);
    i_rx_full_clr <= 1'b0;
    i_err_clr <= 3'h0;
  endtask
  initial begin
    tick(40000);
    errors++;
    report_and_stop();
  end
  initial begin
    tick(2);
    i_rst_n <= 1'b1;
    i_rx_enable_bit <= 1'b1;
    tick(1);
    chk_bit(o_tx_line, 1'b1);
    // Every length, stop and tag select; parity odd for 8 bits, even for 7; full duplex, two chained writes
    for (int f = 0; f < 16; f++) begin
      i_transmit_enable <= 1'b0;
      set_fmt(f[3:0]);
      tick(3);
      chk_bit(o_tx_empty_flag, 1'b1);
      i_transmit_enable <= 1'b1;
      fork
        begin
          write_byte(8'hA5 ^ f[7:0], f[0]);
          write_byte(8'h3C + f[7:0], ~f[0]);
        end
        rx(body(8'h96 ^ f[7:0], f[1]));
      join
      for (k = 0; k < 3000 && peer.rx_q.size() < 2; k++) tick(1);
      chk_word(peer.rx_q.pop_front(), body(8'hA5 ^ f[7:0], f[0]));
      chk_word(peer.rx_q.pop_front(), body(8'h3C + f[7:0], ~f[0]));
      chk_bit(o_tx_done_flag, 1'b1);
      chk_bit(o_rx_full_flag, 1'b1);
      if (f[3]) chk_bit(o_rx_tag, f[1]);
      chk_word(12'(o_rx_data_buffer), 12'(body(8'h96 ^ f[7:0], f[1]) & (f[0] ? 12'h7F : 12'hFF)));
      clr(1'b1, 3'h0);
    end
    set_fmt(4'h6);
    tick(3);
    rx(body(8'h5A, 1'b0) ^ 12'h100);
    chk_word(12'(o_err_flags), 12'(1 << `AST_ERR_PARITY));
    chk_bit(o_rx_full_flag, 1'b0);
    chk_word(12'(o_rx_data_buffer), 12'h05A);
    chk_bit(o_rx_error_irq, 1'b1);
    rx(body(8'h11, 1'b0));
    chk_word(12'(o_rx_data_buffer), 12'h05A);
    clr(1'b0, 3'h7);
    rx(body(8'h22, 1'b0) ^ 12'h400);
    chk_word(12'(o_err_flags), 12'h000);
    chk_word(12'(o_rx_data_buffer), 12'h022);
    rx(body(8'h33, 1'b0));
    chk_word(12'(o_err_flags), 12'(1 << `AST_ERR_OVERRUN));
    chk_word(12'(o_rx_data_buffer), 12'h022);
    clr(1'b1, 3'h7);
    rx(body(8'h44, 1'b0) ^ 12'h200);
    chk_word(12'(o_err_flags), 12'(1 << `AST_ERR_FRAMING));
    chk_word(12'(o_rx_data_buffer), 12'h044);
    // Receiver off: a frame must not set the full flag or change the buffer
    i_rx_enable_bit <= 1'b0;
    clr(1'b0, 3'h7);
    rx(body(8'h55, 1'b0));
    chk_bit(o_rx_full_flag, 1'b0);
    chk_word(12'(o_rx_data_buffer), 12'h044);
    i_rx_enable_bit <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      @(posedge i_clk);
      {i_sync_mode_sel, i_clk_src_ext, i_clk_pin_out} <= c[2:0];
      @(negedge i_clk);
      chk_bit(o_sck_oe_n, !(!c[1] && (c[2] || c[0])));
    end
    report_and_stop();
  end
endmodule
bind ast_serial_top ast_serial_chk u_chk (.*);
